// ---- rtl/dfs_supervisor.sv ----
// Drive fault state supervisor: error classes, operating states and error memory
// Operation
// - Class 0: warning only, movement continues
// - Class 1: quick stop, amplifier stays on
// - Class 2: quick stop, then switch off
// - Class 3: switch off immediately
// - Class 4: switch off, reset only by power-off
// - Halt records nothing; software stop records A306
// - Limit switch: quick stop, A302 to both
// - Class 1 error: quick stop, code to both
// - Class 2 to 4: fault, code to both
// - Keep last cause and ten error entries
// - Display gets cause only; bus gets history
// - Report which safety input tripped, unconfigurable
// - State 1 initialise, state 2 not ready
// - State 3 blocks switch-on, state 4 ready
// - State 5: no current, no mode
// - State 6: run mode or hold halted
// - States 7, 8, 9: quick stop, reacting, fault
// - Class 2-4 from any state except 1 to 8, then 9
// - State 6 class 1 or quick stop to 7
`timescale 1ns/10ps
module dfs_supervisor
  import dfs_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic INIT_DONE,
  input wire logic COMMISSIONED,
  input wire logic POWER_OK,
  input wire logic POSITIVE_LIMIT_INPUT,
  input wire logic NEGATIVE_LIMIT_INPUT,
  input wire logic SAFETY_REMOVAL_IN_A_B,
  input wire logic SAFETY_REMOVAL_IN_B_B,
  input wire logic CMD_ENABLE,
  input wire logic CMD_DISABLE,
  input wire logic CMD_QUICK_STOP,
  input wire logic CMD_FAULT_RESET,
  input wire logic CMD_HALT,
  input wire logic ERR_VALID,
  input wire logic [2:0] ERR_CLASS,
  input wire logic [15:0] ERR_CODE,
  input wire logic STANDSTILL,
  input wire logic [3:0] HIST_INDEX,
  output logic [3:0] OP_STATE,
  output logic AMP_ON,
  output logic CTRL_ON,
  output logic QUICK_STOP_RUN,
  output logic MODE_ACTIVE,
  output logic HALTED,
  output logic WARNING,
  output logic PWR_OFF_LOCK,
  output logic SAFETY_TRIP_A,
  output logic SAFETY_TRIP_B,
  output logic [15:0] DISPLAY_CAUSE,
  output logic [15:0] BUS_CAUSE,
  output logic [15:0] BUS_HIST_CODE,
  output logic [3:0] BUS_HIST_COUNT
);

  // Returns the next ring slot with wrap after the last entry
  function automatic logic [3:0] ring_next(input logic [3:0] p);
    ring_next = (p == DFS_HIST_LAST) ? 4'h0 : p + 4'h1;
  endfunction : ring_next

  // Two-stage synchronisers for pin inputs
  logic [1:0] lim_p_s, lim_n_s, saf_a_s, saf_b_s;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      lim_p_s <= 2'h0;
      lim_n_s <= 2'h0;
      saf_a_s <= 2'h3;
      saf_b_s <= 2'h3;
    end else begin
      lim_p_s <= {lim_p_s[0], POSITIVE_LIMIT_INPUT};
      lim_n_s <= {lim_n_s[0], NEGATIVE_LIMIT_INPUT};
      saf_a_s <= {saf_a_s[0], SAFETY_REMOVAL_IN_A_B};
      saf_b_s <= {saf_b_s[0], SAFETY_REMOVAL_IN_B_B};
    end
  end
  logic limit_hit, saf_ok, limit_prev;
  assign saf_ok = saf_a_s[1] && saf_b_s[1];

  // Limit switch edge so a held switch records one event
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      limit_prev <= 1'b0;
    end else begin
      limit_prev <= lim_p_s[1] | lim_n_s[1];
    end
  end
  assign limit_hit = (lim_p_s[1] | lim_n_s[1]) && !limit_prev;

  // Event decode
  logic err_hi, err_q, err_warn;
  assign err_hi = ERR_VALID && (ERR_CLASS >= DFS_CLASS_QSTOP_OFF)
                  && (ERR_CLASS <= DFS_CLASS_UNCTRL);
  assign err_q = ERR_VALID && (ERR_CLASS == DFS_CLASS_QSTOP);
  assign err_warn = ERR_VALID && (ERR_CLASS == DFS_CLASS_WARN);

  dfs_state_t state, next_state;
  logic [2:0] react_class;

  // Operating state transitions
  always_comb begin
    next_state = state;
    case (state)
      DFS_ST_START: begin
        if (INIT_DONE) next_state = DFS_ST_NOT_READY;
      end
      DFS_ST_NOT_READY: begin
        if (COMMISSIONED) next_state = DFS_ST_ON_DISABLED;
      end
      DFS_ST_ON_DISABLED: begin
        if (POWER_OK && saf_ok) next_state = DFS_ST_READY;
      end
      DFS_ST_READY: begin
        if (!POWER_OK || !saf_ok || CMD_DISABLE) begin
          next_state = DFS_ST_ON_DISABLED;
        end else if (CMD_ENABLE) begin
          next_state = DFS_ST_SWITCHED_ON;
        end
      end
      DFS_ST_SWITCHED_ON: begin
        if (CMD_DISABLE) next_state = DFS_ST_ON_DISABLED;
        else if (CMD_ENABLE) next_state = DFS_ST_OP_ENABLED;
      end
      DFS_ST_OP_ENABLED: begin
        if (CMD_DISABLE) next_state = DFS_ST_ON_DISABLED;
        else if (err_q || CMD_QUICK_STOP || limit_hit) next_state = DFS_ST_QSTOP;
      end
      DFS_ST_QSTOP: begin
        if (CMD_DISABLE) next_state = DFS_ST_ON_DISABLED;
        else if (CMD_FAULT_RESET) next_state = DFS_ST_OP_ENABLED;
      end
      DFS_ST_FAULT_REACT: begin
        if (react_class != DFS_CLASS_QSTOP_OFF || STANDSTILL) begin
          next_state = DFS_ST_FAULT;
        end
      end
      DFS_ST_FAULT: begin
        if (CMD_FAULT_RESET && !PWR_OFF_LOCK) next_state = DFS_ST_ON_DISABLED;
      end
      default: next_state = DFS_ST_START;
    endcase
    if (err_hi && state != DFS_ST_START) next_state = DFS_ST_FAULT_REACT;
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state <= DFS_ST_START;
    end else begin
      state <= next_state;
    end
  end

  // Class of the reaction in progress and power-off lock for class 4
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      react_class <= DFS_CLASS_WARN;
      PWR_OFF_LOCK <= 1'b0;
    end else if (err_hi && state != DFS_ST_START) begin
      react_class <= ERR_CLASS;
      if (ERR_CLASS == DFS_CLASS_UNCTRL) PWR_OFF_LOCK <= 1'b1;
    end
  end

  // Drive outputs per state and reaction class
  always_comb begin
    OP_STATE = state;
    AMP_ON = 1'b0;
    QUICK_STOP_RUN = 1'b0;
    MODE_ACTIVE = 1'b0;
    case (state)
      DFS_ST_SWITCHED_ON: AMP_ON = 1'b0;
      DFS_ST_OP_ENABLED: begin
        AMP_ON = 1'b1;
        MODE_ACTIVE = !CMD_HALT;
      end
      DFS_ST_QSTOP: begin
        AMP_ON = 1'b1;
        QUICK_STOP_RUN = 1'b1;
      end
      DFS_ST_FAULT_REACT: begin
        AMP_ON = (react_class == DFS_CLASS_QSTOP_OFF);
        QUICK_STOP_RUN = (react_class == DFS_CLASS_QSTOP_OFF);
      end
      default: AMP_ON = 1'b0;
    endcase
    CTRL_ON = AMP_ON;
    HALTED = (state == DFS_ST_OP_ENABLED) && CMD_HALT;
  end

  // Warning flag for class 0, no state change
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      WARNING <= 1'b0;
    end else begin
      WARNING <= err_warn;
    end
  end

  // Safety input trip report, fixed wiring with no configuration
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      SAFETY_TRIP_A <= 1'b0;
      SAFETY_TRIP_B <= 1'b0;
    end else begin
      SAFETY_TRIP_A <= !saf_a_s[1];
      SAFETY_TRIP_B <= !saf_b_s[1];
    end
  end

  // Recording of cause and error memory
  logic rec_cause, rec_hist;
  logic [15:0] rec_code;
  always_comb begin
    rec_cause = 1'b0;
    rec_hist = 1'b0;
    rec_code = DFS_CODE_NONE;
    if (err_hi && state != DFS_ST_START) begin
      rec_cause = 1'b1;
      rec_hist = 1'b1;
      rec_code = ERR_CODE;
    end else if (state == DFS_ST_OP_ENABLED) begin
      if (err_q) begin
        rec_cause = 1'b1;
        rec_hist = 1'b1;
        rec_code = ERR_CODE;
      end else if (limit_hit) begin
        rec_cause = 1'b1;
        rec_hist = 1'b1;
        rec_code = DFS_CODE_LIMIT;
      end else if (CMD_QUICK_STOP && !CMD_DISABLE) begin
        rec_cause = 1'b1;
        rec_code = DFS_CODE_SW_STOP;
      end
    end
  end

  logic [15:0] last_interruption_cause;
  logic [15:0] hist_mem [DFS_HIST_DEPTH];
  logic [3:0] wr_ptr;

  // Last interruption cause
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      last_interruption_cause <= DFS_CODE_NONE;
    end else if (rec_cause) begin
      last_interruption_cause <= rec_code;
    end
  end

  // Ten-entry ring, oldest entry overwritten
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      wr_ptr <= 4'h0;
      BUS_HIST_COUNT <= 4'h0;
      for (int i = 0; i < DFS_HIST_DEPTH; i++) hist_mem[i] <= DFS_CODE_NONE;
    end else if (rec_hist) begin
      hist_mem[wr_ptr] <= rec_code;
      wr_ptr <= ring_next(wr_ptr);
      if (BUS_HIST_COUNT != 4'hA) BUS_HIST_COUNT <= BUS_HIST_COUNT + 4'h1;
    end
  end

  // Read ports: display sees cause only, bus sees cause and history
  logic [4:0] rd_sum;
  logic [3:0] rd_idx;
  assign rd_sum = {1'b0, wr_ptr} + 5'h9 - {1'b0, HIST_INDEX};
  assign rd_idx = (rd_sum >= 5'hA) ? rd_sum[3:0] - 4'hA : rd_sum[3:0];
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      DISPLAY_CAUSE <= DFS_CODE_NONE;
      BUS_CAUSE <= DFS_CODE_NONE;
      BUS_HIST_CODE <= DFS_CODE_NONE;
    end else begin
      DISPLAY_CAUSE <= last_interruption_cause;
      BUS_CAUSE <= last_interruption_cause;
      BUS_HIST_CODE <= (HIST_INDEX < 4'hA) ? hist_mem[rd_idx] : DFS_CODE_NONE;
    end
  end

  // Checks
  AST_HI_TO_REACT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    err_hi && state != DFS_ST_START |=> state == DFS_ST_FAULT_REACT)
    else $error("class 2-4 error did not enter fault reaction");
  AST_Q_TO_QSTOP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_OP_ENABLED && (err_q || CMD_QUICK_STOP) && !err_hi && !CMD_DISABLE
    |=> state == DFS_ST_QSTOP)
    else $error("quick stop not entered");
  AST_QSTOP_AMP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_QSTOP |-> AMP_ON && CTRL_ON)
    else $error("amplifier off in quick stop");
  AST_FATAL_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_FAULT_REACT && react_class >= DFS_CLASS_FATAL |-> !AMP_ON)
    else $error("amplifier on in fatal reaction");
  AST_CL2_WAIT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_FAULT_REACT && react_class == DFS_CLASS_QSTOP_OFF && !STANDSTILL
    && !err_hi |=> state == DFS_ST_FAULT_REACT)
    else $error("class 2 left reaction before standstill");
  AST_LOCK: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    PWR_OFF_LOCK && state == DFS_ST_FAULT |=> state != DFS_ST_ON_DISABLED)
    else $error("class 4 fault was reset");
  AST_LIMIT_CODE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_OP_ENABLED && limit_hit && !ERR_VALID |=> ##1
    DISPLAY_CAUSE == DFS_CODE_LIMIT)
    else $error("limit code not shown");
  AST_SWSTOP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_OP_ENABLED && CMD_QUICK_STOP && !ERR_VALID && !limit_hit
    && !CMD_DISABLE |=> last_interruption_cause == DFS_CODE_SW_STOP
    && $stable(BUS_HIST_COUNT))
    else $error("software stop recorded wrongly");
  AST_WARN: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    err_warn && state == DFS_ST_OP_ENABLED && !CMD_DISABLE && !CMD_QUICK_STOP
    && !limit_hit |=> state == DFS_ST_OP_ENABLED && WARNING)
    else $error("warning interrupted movement");
  AST_COUNT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    BUS_HIST_COUNT <= 4'hA)
    else $error("history count above ten");
  AST_CL1_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_OP_ENABLED && err_q |=> last_interruption_cause == $past(ERR_CODE))
    else $error("class 1 code not recorded");
  AST_HALT_NO_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == DFS_ST_OP_ENABLED && CMD_HALT && !ERR_VALID && !limit_hit && !CMD_QUICK_STOP
    |=> $stable(last_interruption_cause))
    else $error("halt recorded a cause");
  AST_COUNT_STEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rec_hist && BUS_HIST_COUNT != 4'hA |=> BUS_HIST_COUNT == $past(BUS_HIST_COUNT) + 4'h1)
    else $error("history count did not advance");
  AST_RING_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    rec_hist |=> hist_mem[$past(wr_ptr)] == $past(rec_code))
    else $error("history entry not written");

  // Coverage of the main scenarios
  COV_QSTOP: cover property (@(posedge SYS_CLK) state == DFS_ST_QSTOP);
  COV_FAULT: cover property (@(posedge SYS_CLK) state == DFS_ST_FAULT);
  COV_RING_FULL: cover property (@(posedge SYS_CLK) BUS_HIST_COUNT == 4'hA && rec_hist);
  COV_LOCKED: cover property (@(posedge SYS_CLK) state == DFS_ST_FAULT && PWR_OFF_LOCK);
  COV_SLOW_STOP: cover property (@(posedge SYS_CLK)
    QUICK_STOP_RUN && state == DFS_ST_FAULT_REACT);

endmodule : dfs_supervisor

// ---- rtl/dfs_pkg.sv ----
// Package with constants and types for the drive fault state supervisor
package dfs_pkg;
  localparam int DFS_CODE_W = 16;
  localparam int DFS_HIST_DEPTH = 10;
  localparam logic [3:0] DFS_HIST_LAST = 4'h9;
  localparam logic [15:0] DFS_CODE_NONE = 16'h0000;
  localparam logic [15:0] DFS_CODE_SW_STOP = 16'hA306;
  localparam logic [15:0] DFS_CODE_LIMIT = 16'hA302;
  localparam logic [2:0] DFS_CLASS_WARN = 3'h0;
  localparam logic [2:0] DFS_CLASS_QSTOP = 3'h1;
  localparam logic [2:0] DFS_CLASS_QSTOP_OFF = 3'h2;
  localparam logic [2:0] DFS_CLASS_FATAL = 3'h3;
  localparam logic [2:0] DFS_CLASS_UNCTRL = 3'h4;

  typedef enum logic [3:0] {
    DFS_ST_START = 4'h1,
    DFS_ST_NOT_READY = 4'h2,
    DFS_ST_ON_DISABLED = 4'h3,
    DFS_ST_READY = 4'h4,
    DFS_ST_SWITCHED_ON = 4'h5,
    DFS_ST_OP_ENABLED = 4'h6,
    DFS_ST_QSTOP = 4'h7,
    DFS_ST_FAULT_REACT = 4'h8,
    DFS_ST_FAULT = 4'h9
  } dfs_state_t;
endpackage : dfs_pkg

// ---- testbench/dfs_bus_reader.sv ----
// Fieldbus master model that reads the error history
`timescale 1ns/10ps
module dfs_bus_reader (
  input wire logic SYS_CLK,
  output logic [3:0] HIST_INDEX,
  input wire logic [15:0] BUS_HIST_CODE
);
  initial HIST_INDEX = 4'h0;
  // Set the index, let the registered answer land, then take it
  task automatic read(input logic [3:0] idx, output logic [15:0] code);
    @(posedge SYS_CLK) HIST_INDEX <= idx;
    repeat (2) @(posedge SYS_CLK);
    #1 code = BUS_HIST_CODE;
  endtask : read
endmodule : dfs_bus_reader

// ---- testbench/drive_fault_state_supervisor_tb_top.sv ----
// Self-checking bench for the drive fault state supervisor
`timescale 1ns/10ps
module drive_fault_state_supervisor_tb_top;
  import dfs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic lim_p = 1'b0;
  logic lim_n = 1'b0;
  logic saf_a_b = 1'b1;
  logic saf_b_b = 1'b1;
  logic init_d = 1'b0;
  logic comm = 1'b0;
  logic pwr_ok = 1'b0;
  logic halt = 1'b0;
  logic stand = 1'b0;
  logic e_v = 1'b0;
  logic [3:0] cmd = 4'h0; // Enable, disable, quick stop, fault reset
  logic [2:0] e_c = 3'h0;
  logic [15:0] e_code = 16'h0000;
  logic [3:0] h_idx, op, h_cnt;
  logic amp, ctl, qsr, mode, halted, warn, lock, trip_a, trip_b, warn_seen;
  logic [15:0] d_cause, b_cause, h_code, rd, code;
  logic [15:0] hist[$];
  int num_errors = 0;
  int check_count = 0;
  // Clock and sticky warning monitor
  always #20 clk = ~clk;
  initial warn_seen = 1'b0;
  always @(posedge clk) if (warn === 1'b1) warn_seen <= 1'b1;
  dfs_supervisor dfs_supervisor_i (.SYS_CLK(clk), .RST_B(rst_b), .INIT_DONE(init_d),
    .COMMISSIONED(comm), .POWER_OK(pwr_ok), .POSITIVE_LIMIT_INPUT(lim_p),
    .NEGATIVE_LIMIT_INPUT(lim_n), .SAFETY_REMOVAL_IN_A_B(saf_a_b),
    .SAFETY_REMOVAL_IN_B_B(saf_b_b), .CMD_ENABLE(cmd[0]), .CMD_DISABLE(cmd[1]),
    .CMD_QUICK_STOP(cmd[2]), .CMD_FAULT_RESET(cmd[3]), .CMD_HALT(halt),
    .ERR_VALID(e_v), .ERR_CLASS(e_c), .ERR_CODE(e_code), .STANDSTILL(stand),
    .HIST_INDEX(h_idx), .OP_STATE(op), .AMP_ON(amp), .CTRL_ON(ctl),
    .QUICK_STOP_RUN(qsr), .MODE_ACTIVE(mode), .HALTED(halted), .WARNING(warn),
    .PWR_OFF_LOCK(lock), .SAFETY_TRIP_A(trip_a), .SAFETY_TRIP_B(trip_b),
    .DISPLAY_CAUSE(d_cause), .BUS_CAUSE(b_cause), .BUS_HIST_CODE(h_code),
    .BUS_HIST_COUNT(h_cnt));
  dfs_bus_reader dfs_bus_reader_i (.SYS_CLK(clk), .HIST_INDEX(h_idx),
    .BUS_HIST_CODE(h_code));
  // Comparison and expectation helpers
  task automatic chk(input string name, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic void push(input logic [15:0] c);
    hist.push_front(c);
    if (hist.size() > DFS_HIST_DEPTH) void'(hist.pop_back());
  endfunction : push
  function automatic logic [15:0] exp_hist(input int i);
    return (i < hist.size()) ? hist[i] : DFS_CODE_NONE;
  endfunction : exp_hist
  task automatic wait_st(input logic [3:0] s);
    #1;
    for (int i = 0; i < 20 && op !== s; i++) begin
      @(posedge clk);
      #1;
    end
    chk("op_state", op, s);
  endtask : wait_st
  task automatic pulse(input int b);
    @(posedge clk) cmd <= 4'h1 << b;
    @(posedge clk) cmd <= 4'h0;
  endtask : pulse
  task automatic err(input logic [2:0] c, input logic [15:0] v);
    @(posedge clk) begin
      e_v <= 1'b1;
      e_c <= c;
      e_code <= v;
    end
    @(posedge clk) e_v <= 1'b0;
    if (c != DFS_CLASS_WARN) push(v);
  endtask : err
  task automatic chk_cause(input logic [15:0] exp);
    repeat (2) @(posedge clk);
    #1 chk("display_cause", d_cause, exp);
    chk("bus_cause", b_cause, exp);
    chk("hist_count", {12'h000, h_cnt}, 16'(hist.size()));
  endtask : chk_cause
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Watchdog far beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(37307));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("op_state", op, 16'h1);
    @(posedge clk) init_d <= 1'b1;
    wait_st(4'h2);
    @(posedge clk) comm <= 1'b1;
    wait_st(4'h3);
    repeat (2) @(posedge clk);
    #1 chk("blocked", {op, amp}, 16'h6);
    @(posedge clk) pwr_ok <= 1'b1;
    wait_st(4'h4);
    chk("amp_on", amp, 16'h0);
    pulse(0);
    wait_st(4'h5);
    chk("mode", mode, 16'h0);
    pulse(0);
    wait_st(4'h6);
    chk("amp_on", amp, 16'h1);
    @(posedge clk) halt <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("halted", {halted, mode}, 16'h2);
    wait_st(4'h6);
    chk_cause(DFS_CODE_NONE);
    @(posedge clk) halt <= 1'b0;
    err(DFS_CLASS_WARN, 16'($urandom()));
    repeat (3) @(posedge clk);
    #1 chk("warning", warn_seen, 16'h1);
    wait_st(4'h6);
    pulse(2);
    wait_st(4'h7);
    chk_cause(DFS_CODE_SW_STOP);
    pulse(3);
    wait_st(4'h6);
    @(posedge clk) lim_p <= 1'b1;
    push(DFS_CODE_LIMIT);
    wait_st(4'h7);
    chk_cause(DFS_CODE_LIMIT);
    @(posedge clk) lim_p <= 1'b0;
    pulse(3);
    wait_st(4'h6);
    code = 16'($urandom());
    err(DFS_CLASS_QSTOP, code);
    wait_st(4'h7);
    chk("amp_qs", {amp, ctl, qsr}, 16'h7);
    chk_cause(code);
    pulse(1);
    wait_st(4'h3);
    chk("amp_off", {amp, ctl}, 16'h0);
    wait_st(4'h4);
    pulse(0);
    wait_st(4'h5);
    pulse(1);
    wait_st(4'h3);
    wait_st(4'h4);
    pulse(0);
    wait_st(4'h5);
    pulse(0);
    wait_st(4'h6);
    @(posedge clk) lim_n <= 1'b1;
    push(DFS_CODE_LIMIT);
    wait_st(4'h7);
    chk_cause(DFS_CODE_LIMIT);
    @(posedge clk) lim_n <= 1'b0;
    pulse(3);
    wait_st(4'h6);
    code = 16'($urandom());
    err(DFS_CLASS_QSTOP_OFF, code);
    wait_st(4'h8);
    chk("amp_qs", {amp, qsr}, 16'h3);
    chk_cause(code);
    @(posedge clk) stand <= 1'b1;
    wait_st(4'h9);
    chk("amp_off", {amp, ctl}, 16'h0);
    pulse(3);
    wait_st(4'h3);
    err(DFS_CLASS_FATAL, 16'($urandom()));
    wait_st(4'h8);
    chk("amp_off", amp, 16'h0);
    wait_st(4'h9);
    for (int i = 0; i < 11; i++) begin
      err(3'h2 + 3'($urandom_range(1)), 16'($urandom()));
      wait_st(4'h9);
    end
    for (int i = 0; i < 11; i++) begin
      dfs_bus_reader_i.read(4'(i), rd);
      chk("hist_code", rd, exp_hist(i));
    end
    chk_cause(hist[0]);
    pulse(3);
    wait_st(4'h4);
    @(posedge clk) saf_a_b <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("trip", {trip_a, trip_b}, 16'h2);
    wait_st(4'h3);
    @(posedge clk) saf_a_b <= 1'b1;
    @(posedge clk) saf_b_b <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("trip", {trip_a, trip_b}, 16'h1);
    wait_st(4'h3);
    @(posedge clk) saf_b_b <= 1'b1;
    err(DFS_CLASS_UNCTRL, 16'($urandom()));
    wait_st(4'h9);
    chk("lock", lock, 16'h1);
    pulse(3);
    repeat (3) @(posedge clk);
    #1 chk("op_state", op, 16'h9);
    @(posedge clk) rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("reset", {lock, op}, 16'h1);
    @(posedge clk) rst_b <= 1'b1;
    wait_st(4'h4);
    chk("reset_count", {12'h000, h_cnt}, 16'h0);
    chk("reset_cause", d_cause, DFS_CODE_NONE);
    @(posedge clk) pwr_ok <= 1'b0;
    wait_st(4'h3);
    conclude();
  end
endmodule : drive_fault_state_supervisor_tb_top
